// >>> rtl/sfd_decoder.sv
// Contract
// - select falling starts an instruction; outside continuous read mode the first byte on line0 is the opcode
// - input bits taken on rising serial clock, most significant bit first
// - select rising ends the instruction
// - reads may end after any bit; output just stops at select rising
// - write, program, erase discarded unless ended on a whole byte
// - while busy every instruction except status read is ignored
// - opcode steers address, mode, dummy and data phases; some are single byte
// - data bytes move msb first; read data driven during output phases
// - 05h returns status low byte, 35h high byte, repeated until select rises
// - 06h, 50h, 04h latch control; 01h takes one or two status bytes, low first
// - 02h and 32h take three address bytes then data; 32h data by nibbles
// - erase 20h, 52h, d8h with address; c7h or 60h chip erase alone
// - 75h suspend, 7ah resume, b9h power-down, all single byte
// - ffh ffh leaves continuous read mode
// - 03h data right after address; 0bh, 3bh, 6bh insert one dummy byte
// - dual output: line1 odd bits, line0 even bits, high pair first
// - bbh address and mode bits on two lines, line1 odd bits
// - quad output sends high nibble then low nibble on lines 3..0
// - quad address then mode bits four per clock, high nibble first
// - ebh leaves four dummy clocks after mode bits before data
// - e7h two dummy clocks after mode bits, e3h none
// - 77h takes wrap bits from lines 0..2 on the seventh quad clock
// - id codes: part byte for abh, maker byte then part byte for 90h, maker byte then 16 bits for 9fh
// - write latch must be set before program or erase is taken; status write also taken after 50h without it
// - status read is accepted at any time outside continuous read mode, even while busy
`timescale 1ns/10ps
module sfd_decoder #(
  parameter logic [7:0] MAKER_CODE = 8'ha5,  // arbitrary value
  parameter logic [7:0] PART_CODE = 8'h3c,  // arbitrary value
  parameter logic [15:0] PART_CODE16 = 16'h5a3c  // arbitrary value
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic line0,
  output logic line0_drv,
  output logic line0_en,
  input wire logic line1,
  output logic line1_drv,
  output logic line1_en,
  input wire logic line2,
  output logic line2_drv,
  output logic line2_en,
  input wire logic line3,
  output logic line3_drv,
  output logic line3_en,
  input wire logic busy,
  input wire logic [7:0] status_lo,
  input wire logic [7:0] status_hi,
  output logic [23:0] rd_addr,
  input wire logic [7:0] rd_byte,
  output logic cmd_valid,
  output logic [7:0] cmd_op,
  output logic [23:0] cmd_arg,
  output logic cmd_drop,
  output logic write_latch_bit,
  output logic vol_enable,
  output logic power_down,
  output logic cont_mode,
  output logic [2:0] wrap_length_bits,
  output logic prog_overrun,
  output logic [7:0] prog_data,
  output logic prog_valid,
  input wire logic prog_ready
);
  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic [1:0] prev;
    sfd_pkg::sfd_state_t st;
    logic [5:0] cnt;
    logic [2:0] bits;
    logic [1:0] nb;
    logic [31:0] sr;
    logic [7:0] op;
    logic [23:0] addr;
    logic [7:0] obyte;
    logic [2:0] ocnt;
    logic [1:0] bcnt;
    logic [3:0] drv;
    logic [3:0] en;
    logic wlatch;
    logic vol;
    logic cont;
    logic pd;
    logic [2:0] wrap;
    logic cmd_valid;
    logic cmd_drop;
    logic [7:0] cmd_op;
    logic [23:0] cmd_arg;
    logic push;
    logic [7:0] push_data;
    logic overrun;
  } sfd_regs_t;

  sfd_regs_t q, d;
  logic [1:0] rst_q;
  logic fifo_ready;

  function automatic logic has_mode(input logic [7:0] o);
    return o == sfd_pkg::OP_DUAL_IO || o == sfd_pkg::OP_QUAD_IO ||
      o == sfd_pkg::OP_WORD_QIO || o == sfd_pkg::OP_OCTAL_QIO;
  endfunction

  function automatic logic is_read(input logic [7:0] o);
    return has_mode(o) || o == sfd_pkg::OP_READ || o == sfd_pkg::OP_FAST ||
      o == sfd_pkg::OP_FAST_DUAL || o == sfd_pkg::OP_FAST_QUAD ||
      o == sfd_pkg::OP_WAKE_ID || o == sfd_pkg::OP_MAKER_ID;
  endfunction

  function automatic logic wr_addr(input logic [7:0] o);
    return o == sfd_pkg::OP_PROG || o == sfd_pkg::OP_QPROG || o == sfd_pkg::OP_ERASE_4K ||
      o == sfd_pkg::OP_ERASE_32K || o == sfd_pkg::OP_ERASE_64K;
  endfunction

  function automatic logic gated(input logic [7:0] o);
    return wr_addr(o) || o == sfd_pkg::OP_STAT_WR || o == sfd_pkg::OP_CHIP_A ||
      o == sfd_pkg::OP_CHIP_B;
  endfunction

  function automatic logic is_write(input logic [7:0] o);
    return gated(o) || o == sfd_pkg::OP_WR_EN || o == sfd_pkg::OP_VOL_WR_EN ||
      o == sfd_pkg::OP_WR_DIS || o == sfd_pkg::OP_SUSPEND || o == sfd_pkg::OP_RESUME ||
      o == sfd_pkg::OP_SLEEP || o == sfd_pkg::OP_MODE_RST;
  endfunction

  function automatic logic [2:0] addr_w(input logic [7:0] o);
    if (o == sfd_pkg::OP_DUAL_IO)
      return 3'h2;
    else if (has_mode(o))
      return 3'h4;
    else
      return 3'h1;
  endfunction

  function automatic logic [2:0] out_w(input logic [7:0] o);
    if (o == sfd_pkg::OP_FAST_DUAL || o == sfd_pkg::OP_DUAL_IO)
      return 3'h2;
    else if (o == sfd_pkg::OP_FAST_QUAD || has_mode(o) && o != sfd_pkg::OP_DUAL_IO)
      return 3'h4;
    else
      return 3'h1;
  endfunction

  function automatic logic [5:0] dummy_len(input logic [7:0] o);
    if (o == sfd_pkg::OP_FAST || o == sfd_pkg::OP_FAST_DUAL || o == sfd_pkg::OP_FAST_QUAD)
      return sfd_pkg::DUMMY_FAST;
    else if (o == sfd_pkg::OP_QUAD_IO)
      return sfd_pkg::DUMMY_QIO;
    else if (o == sfd_pkg::OP_WORD_QIO)
      return sfd_pkg::DUMMY_WORD;
    else
      return 6'h00;
  endfunction

  function automatic logic [5:0] phase_len(input sfd_pkg::sfd_state_t s, input logic [7:0] o);
    logic [2:0] aw;
    aw = addr_w(o);
    if (s == sfd_pkg::ST_OPC)
      return sfd_pkg::OPC_CLK;
    else if (s == sfd_pkg::ST_ADDR)
      return aw == 3'h1 ? sfd_pkg::ADDR_CLK_X1 :
        aw == 3'h2 ? sfd_pkg::ADDR_CLK_X2 : sfd_pkg::ADDR_CLK_X4;
    else if (s == sfd_pkg::ST_MODE)
      return aw == 3'h2 ? sfd_pkg::MODE_CLK_X2 : sfd_pkg::MODE_CLK_X4;
    else
      return dummy_len(o);
  endfunction

  function automatic sfd_pkg::sfd_state_t decode(input logic [7:0] o, input logic bsy);
    if (bsy && o != sfd_pkg::OP_STAT_LO && o != sfd_pkg::OP_STAT_HI)
      return sfd_pkg::ST_IGN;
    else if (o == sfd_pkg::OP_STAT_LO || o == sfd_pkg::OP_STAT_HI || o == sfd_pkg::OP_JEDEC_ID)
      return sfd_pkg::ST_DOUT;
    else if (is_read(o) || wr_addr(o))
      return sfd_pkg::ST_ADDR;
    else if (is_write(o) || o == sfd_pkg::OP_WRAP)
      return sfd_pkg::ST_DIN;
    else
      return sfd_pkg::ST_IGN;
  endfunction

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_q <= 2'h0;
    end
    else
    begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end

  always_comb
  begin
    logic [3:0] ln;
    logic rise;
    logic fall;
    logic cs_fall;
    logic cs_rise;
    logic [2:0] w;
    logic [5:0] cnt1;
    logic last;
    logic [31:0] sh;
    logic [2:0] bits1;
    logic [2:0] onext;
    logic [7:0] b;
    logic [7:0] fresh;
    logic perm;
    ln = 4'h0;
    rise = 1'b0;
    fall = 1'b0;
    cs_fall = 1'b0;
    cs_rise = 1'b0;
    w = 3'h1;
    cnt1 = 6'h00;
    last = 1'b0;
    sh = 32'h0;
    bits1 = 3'h0;
    onext = 3'h0;
    b = 8'h00;
    fresh = 8'h00;
    perm = 1'b0;

    d = q;
    d.s1 = {line3, line2, line1, line0, sclk, cs_n};
    d.s2 = q.s1;
    d.prev = q.s2[1:0];
    d.cmd_valid = 1'b0;
    d.cmd_drop = 1'b0;
    d.push = 1'b0;

    ln = q.s2[5:2];
    cs_fall = q.prev[0] && !q.s2[0];
    cs_rise = !q.prev[0] && q.s2[0];
    rise = !q.s2[0] && !q.prev[1] && q.s2[1];
    fall = !q.s2[0] && q.prev[1] && !q.s2[1];

    if (q.st == sfd_pkg::ST_DIN)
      w = (q.op == sfd_pkg::OP_QPROG || q.op == sfd_pkg::OP_WRAP) ? 3'h4 : 3'h1;
    else if (q.st == sfd_pkg::ST_DOUT)
      w = out_w(q.op);
    else if (q.st == sfd_pkg::ST_ADDR || q.st == sfd_pkg::ST_MODE)
      w = addr_w(q.op);
    unique case (w)
      3'h2: sh = {q.sr[29:0], ln[1], ln[0]};
      3'h4: sh = {q.sr[27:0], ln[3], ln[2], ln[1], ln[0]};
      default: sh = {q.sr[30:0], ln[0]};
    endcase
    cnt1 = q.cnt + 6'h01;
    last = cnt1 == phase_len(q.st, q.op);
    bits1 = q.bits + w;
    onext = q.ocnt + w;

    unique case (q.op)
      sfd_pkg::OP_STAT_LO:
      begin
        fresh = status_lo;
        fresh[sfd_pkg::LATCH_BIT] = q.wlatch;
      end
      sfd_pkg::OP_STAT_HI: fresh = status_hi;
      sfd_pkg::OP_JEDEC_ID:
        fresh = q.bcnt == 2'h0 ? MAKER_CODE :
          q.bcnt == 2'h1 ? PART_CODE16[15:8] : PART_CODE16[7:0];
      sfd_pkg::OP_WAKE_ID: fresh = PART_CODE;
      sfd_pkg::OP_MAKER_ID: fresh = q.addr[0] ? PART_CODE : MAKER_CODE;
      default: fresh = rd_byte;
    endcase

    if (cs_rise)
    begin
      d.st = sfd_pkg::ST_IDLE;
      d.en = 4'h0;
      if (q.st == sfd_pkg::ST_DIN && is_write(q.op))
      begin
        perm = !gated(q.op) || q.wlatch ||
          (q.op == sfd_pkg::OP_STAT_WR && q.vol);
        if (q.op == sfd_pkg::OP_STAT_WR && (q.nb == 2'h0 || q.nb == 2'h3))
          perm = 1'b0;
        if (q.bits == 3'h0 && perm)
        begin
          d.cmd_valid = 1'b1;
          d.cmd_op = q.op;
          if (q.op == sfd_pkg::OP_STAT_WR)
            d.cmd_arg = q.nb == 2'h2 ? {8'h01, q.sr[7:0], q.sr[15:8]} :
              {16'h0000, q.sr[7:0]};
          else
            d.cmd_arg = q.addr;
          unique case (q.op)
            sfd_pkg::OP_WR_EN: d.wlatch = 1'b1;
            sfd_pkg::OP_WR_DIS:
            begin
              d.wlatch = 1'b0;
              d.vol = 1'b0;
            end
            sfd_pkg::OP_VOL_WR_EN: d.vol = 1'b1;
            sfd_pkg::OP_SLEEP: d.pd = 1'b1;
            sfd_pkg::OP_MODE_RST: d.cont = 1'b0;
            default:
            begin
              if (gated(q.op))
              begin
                d.wlatch = 1'b0;
                d.vol = 1'b0;
              end
            end
          endcase
        end
        else
        begin
          d.cmd_drop = 1'b1;
        end
      end
    end
    else if (cs_fall)
    begin
      d.cnt = 6'h00;
      d.bits = 3'h0;
      d.nb = 2'h0;
      d.ocnt = 3'h0;
      d.bcnt = 2'h0;
      d.overrun = 1'b0;
      if (q.cont)
        d.st = busy ? sfd_pkg::ST_IGN : sfd_pkg::ST_ADDR;
      else
        d.st = sfd_pkg::ST_OPC;
    end
    else if (rise)
    begin
      unique case (q.st)
        sfd_pkg::ST_OPC:
        begin
          d.sr = sh;
          d.cnt = cnt1;
          if (last)
          begin
            d.op = sh[7:0];
            d.cnt = 6'h00;
            d.st = decode(sh[7:0], busy);
            if (sh[7:0] == sfd_pkg::OP_MODE_RST)
              d.cont = 1'b0;
            if (sh[7:0] == sfd_pkg::OP_WAKE_ID && !busy)
              d.pd = 1'b0;
          end
        end
        sfd_pkg::ST_ADDR:
        begin
          d.sr = sh;
          d.cnt = cnt1;
          if (last)
          begin
            d.addr = sh[23:0];
            d.cnt = 6'h00;
            if (has_mode(q.op))
              d.st = sfd_pkg::ST_MODE;
            else if (dummy_len(q.op) != 6'h00)
              d.st = sfd_pkg::ST_DUMMY;
            else if (is_write(q.op))
              d.st = sfd_pkg::ST_DIN;
            else
              d.st = sfd_pkg::ST_DOUT;
          end
        end
        sfd_pkg::ST_MODE:
        begin
          d.sr = sh;
          d.cnt = cnt1;
          if (last)
          begin
            d.cnt = 6'h00;
            d.cont = sh[5:4] == sfd_pkg::CONT_CODE;
            d.st = dummy_len(q.op) != 6'h00 ? sfd_pkg::ST_DUMMY : sfd_pkg::ST_DOUT;
          end
        end
        sfd_pkg::ST_DUMMY:
        begin
          d.cnt = cnt1;
          if (last)
          begin
            d.cnt = 6'h00;
            d.st = sfd_pkg::ST_DOUT;
          end
        end
        sfd_pkg::ST_DIN:
        begin
          d.sr = sh;
          d.bits = bits1;
          if (q.cnt != sfd_pkg::CNT_MAX)
            d.cnt = cnt1;
          if (q.op == sfd_pkg::OP_WRAP && q.cnt == sfd_pkg::WRAP_CLK)
            d.wrap = ln[2:0];
          if (bits1 == 3'h0)
          begin
            if (q.nb != 2'h3)
              d.nb = q.nb + 2'h1;
            if ((q.op == sfd_pkg::OP_PROG || q.op == sfd_pkg::OP_QPROG) && q.wlatch)
            begin
              if (fifo_ready)
              begin
                d.push = 1'b1;
                d.push_data = sh[7:0];
              end
              else
              begin
                d.overrun = 1'b1;
              end
            end
          end
        end
        sfd_pkg::ST_IDLE, sfd_pkg::ST_DOUT, sfd_pkg::ST_IGN:
        begin
        end
      endcase
    end
    else if (fall && q.st == sfd_pkg::ST_DOUT)
    begin
      b = q.ocnt == 3'h0 ? fresh : q.obyte;
      unique case (w)
        3'h2:
        begin
          d.drv = {2'h0, b[7], b[6]};
          d.en = 4'h3;
        end
        3'h4:
        begin
          d.drv = b[7:4];
          d.en = 4'hf;
        end
        default:
        begin
          d.drv = {2'h0, b[7], 1'b0};
          d.en = 4'h2;
        end
      endcase
      d.obyte = b << w;
      d.ocnt = onext;
      if (onext == 3'h0)
      begin
        d.addr = q.addr + 24'h000001;
        d.bcnt = q.bcnt == 2'h3 ? 2'h3 : q.bcnt + 2'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_q[1])
  begin
    if (!rst_q[1])
    begin
      q <= '0;
      q.s1 <= sfd_pkg::SYNC_IDLE;
      q.s2 <= sfd_pkg::SYNC_IDLE;
      q.prev <= sfd_pkg::PREV_IDLE;
      q.st <= sfd_pkg::ST_IDLE;
    end
    else
    begin
      q <= d;
    end
  end

  sfd_fifo #(
    .WIDTH(sfd_pkg::DATA_W),
    .DEPTH(sfd_pkg::FIFO_DEPTH)
  ) u_prog_fifo (
    .clk(ref_clk),
    .rst_n(rst_q[1]),
    .in_valid(q.push),
    .in_data(q.push_data),
    .in_ready(fifo_ready),
    .out_valid(prog_valid),
    .out_data(prog_data),
    .out_ready(prog_ready)
  );

  assign line0_drv = q.drv[0];
  assign line1_drv = q.drv[1];
  assign line2_drv = q.drv[2];
  assign line3_drv = q.drv[3];
  assign line0_en = q.en[0];
  assign line1_en = q.en[1];
  assign line2_en = q.en[2];
  assign line3_en = q.en[3];
  assign rd_addr = q.addr;
  assign cmd_valid = q.cmd_valid;
  assign cmd_op = q.cmd_op;
  assign cmd_arg = q.cmd_arg;
  assign cmd_drop = q.cmd_drop;
  assign write_latch_bit = q.wlatch;
  assign vol_enable = q.vol;
  assign power_down = q.pd;
  assign cont_mode = q.cont;
  assign wrap_length_bits = q.wrap;
  assign prog_overrun = q.overrun;
endmodule

// >>> rtl/sfd_pkg.sv
package sfd_pkg;

  // instruction codes
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_VOL_WR_EN = 8'h50;
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_STAT_LO = 8'h05;
  localparam logic [7:0] OP_STAT_HI = 8'h35;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_QPROG = 8'h32;
  localparam logic [7:0] OP_ERASE_4K = 8'h20;
  localparam logic [7:0] OP_ERASE_32K = 8'h52;
  localparam logic [7:0] OP_ERASE_64K = 8'hd8;
  localparam logic [7:0] OP_CHIP_A = 8'hc7;
  localparam logic [7:0] OP_CHIP_B = 8'h60;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_SLEEP = 8'hb9;
  localparam logic [7:0] OP_MODE_RST = 8'hff;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0b;
  localparam logic [7:0] OP_FAST_DUAL = 8'h3b;
  localparam logic [7:0] OP_FAST_QUAD = 8'h6b;
  localparam logic [7:0] OP_DUAL_IO = 8'hbb;
  localparam logic [7:0] OP_QUAD_IO = 8'heb;
  localparam logic [7:0] OP_WORD_QIO = 8'he7;
  localparam logic [7:0] OP_OCTAL_QIO = 8'he3;
  localparam logic [7:0] OP_WRAP = 8'h77;
  localparam logic [7:0] OP_WAKE_ID = 8'hab;
  localparam logic [7:0] OP_MAKER_ID = 8'h90;
  localparam logic [7:0] OP_JEDEC_ID = 8'h9f;

  // phase lengths in serial clocks
  localparam logic [5:0] OPC_CLK = 6'h08;
  localparam logic [5:0] ADDR_CLK_X1 = 6'h18;
  localparam logic [5:0] ADDR_CLK_X2 = 6'h0c;
  localparam logic [5:0] ADDR_CLK_X4 = 6'h06;
  localparam logic [5:0] MODE_CLK_X2 = 6'h04;
  localparam logic [5:0] MODE_CLK_X4 = 6'h02;
  localparam logic [5:0] DUMMY_FAST = 6'h08;
  localparam logic [5:0] DUMMY_QIO = 6'h04;
  localparam logic [5:0] DUMMY_WORD = 6'h02;
  localparam logic [5:0] WRAP_CLK = 6'h06;
  localparam logic [5:0] CNT_MAX = 6'h3f;

  // field positions and codes
  localparam int LATCH_BIT = 1;
  localparam logic [1:0] CONT_CODE = 2'h2;

  // reset values
  localparam logic [5:0] SYNC_IDLE = 6'h3f;
  localparam logic [1:0] PREV_IDLE = 2'h3;

  // program data buffer
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_OPC = 8'h02,
    ST_ADDR = 8'h04,
    ST_MODE = 8'h08,
    ST_DUMMY = 8'h10,
    ST_DIN = 8'h20,
    ST_DOUT = 8'h40,
    ST_IGN = 8'h80
  } sfd_state_t;

endpackage

// >>> rtl/sfd_fifo.sv
`timescale 1ns/10ps
// depth must be a power of two
module sfd_fifo #(
  parameter int WIDTH = sfd_pkg::DATA_W,
  parameter int DEPTH = sfd_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } sfd_fifo_regs_t;

  sfd_fifo_regs_t q, d;

  assign in_ready = (q.wp ^ q.rp) != {1'b1, {AW{1'b0}}};
  assign out_valid = q.wp != q.rp;
  assign out_data = q.mem[q.rp[AW-1:0]];

  always_comb
  begin
    d = q;
    if (in_valid && in_ready)
    begin
      d.mem[q.wp[AW-1:0]] = in_data;
      d.wp = q.wp + 1'b1;
    end
    if (out_valid && out_ready)
    begin
      d.rp = q.rp + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end
endmodule

// >>> bench/sfd_properties.sv
`timescale 1ns/10ps
module sfd_properties (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic busy,
  input wire logic line1_drv,
  input wire logic line1_en,
  input wire logic line2_en,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_op,
  input wire logic cmd_drop,
  input wire logic write_latch_bit,
  input wire logic prog_valid,
  input wire logic [7:0] prog_data,
  input wire logic prog_ready
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic [6:0] busy_cnt_q;
  // saturating count of cycles busy has stayed high
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n) busy_cnt_q <= 7'h00;
    else if (!busy) busy_cnt_q <= 7'h00;
    else if (busy_cnt_q != 7'h7f) busy_cnt_q <= busy_cnt_q + 7'h01;
  sequence cs_idle;
    cs_n [*6];
  endsequence
  sequence clk_high;
    sclk [*6];
  endsequence
  a_idle_quiet: assert property (cs_idle |-> !line1_en && !line2_en)
    else $error("output enabled while deselected");
  a_drv_stands: assert property (clk_high |-> $stable(line1_drv) && $stable(line1_en))
    else $error("output changed while clock high");
  a_pulse_once: assert property (cmd_valid |=> !cmd_valid)
    else $error("command pulse too long");
  a_valid_drop_excl: assert property (!(cmd_valid && cmd_drop))
    else $error("command both taken and dropped");
  a_busy_no_cmd: assert property (busy_cnt_q == 7'h7f |-> !cmd_valid)
    else $error("command taken while busy");
  a_latch_rise: assert property ($rose(write_latch_bit) |-> cmd_valid && cmd_op == 8'h06)
    else $error("latch set without enable");
  a_write_needs_latch: assert property (cmd_valid
      && (cmd_op inside {8'h01, 8'h02, 8'h32, 8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60})
      |-> $past(write_latch_bit))
    else $error("write taken with latch clear");
  a_fifo_hold: assert property (prog_valid && !prog_ready |=> prog_valid && $stable(prog_data))
    else $error("buffer head lost while stalled");
endmodule
bind sfd_decoder sfd_properties chk (.ref_clk, .reset_n, .cs_n, .sclk, .busy, .line1_drv,
  .line1_en, .line2_en, .cmd_valid, .cmd_op, .cmd_drop, .write_latch_bit, .prog_valid,
  .prog_data, .prog_ready);

// >>> bench/sfd_host.sv
`timescale 1ns/10ps
module sfd_host (
  input wire logic ref_clk,
  output logic cs_n,
  output logic sclk,
  output logic [3:0] h,
  input wire logic [3:0] io
);
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    h = 4'h0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // mode 0: select moves only with the clock low
  task automatic start();
    wt(1);
    cs_n = 1'b0;
  endtask
  task automatic stop();
    sclk = 1'b0;
    wt(4);
    cs_n = 1'b1;
    h = ~h;
    wt(8);
  endtask
  // 8/w clocks over w lines; released lines toggle so stale levels never match
  task automatic xfer(input logic [7:0] tx, input int w, input bit drv, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < 8 / w; i++)
    begin
      sclk = 1'b0;
      h = drv ? 4'((tx << (i * w)) >> (8 - w)) : ~h;
      wt(4);
      rx = (rx << w) | (w == 1 ? 8'(io[1]) : w == 2 ? 8'(io[1:0]) : 8'(io));
      sclk = 1'b1;
      wt(4);
    end
  endtask
endmodule

// >>> bench/tb_serial_flash_instruction_decoder.sv
`timescale 1ns/10ps
module tb_serial_flash_instruction_decoder;
  logic ref_clk, reset_n, cs_n, sclk, busy, prog_ready, prog_overrun, prog_valid;
  logic line0_drv, line0_en, line1_drv, line1_en, line2_drv, line2_en, line3_drv, line3_en;
  logic cmd_valid, cmd_drop, write_latch_bit, vol_enable, power_down, cont_mode;
  logic [2:0] wrap_length_bits;
  logic [3:0] h;
  logic [7:0] status_lo, status_hi, rd_byte, cmd_op, prog_data, rx;
  logic [23:0] rd_addr, cmd_arg;
  int n_mismatch, checks_done, n_val, n_drop;
  // the block wins where it drives, the host elsewhere
  wire line0 = line0_en ? line0_drv : h[0];
  wire line1 = line1_en ? line1_drv : h[1];
  wire line2 = line2_en ? line2_drv : h[2];
  wire line3 = line3_en ? line3_drv : h[3];
  assign rd_byte = rd_addr[7:0] ^ 8'h5a;
  sfd_decoder dut (.ref_clk, .reset_n, .cs_n, .sclk, .line0, .line0_drv, .line0_en, .line1,
    .line1_drv, .line1_en, .line2, .line2_drv, .line2_en, .line3, .line3_drv, .line3_en, .busy,
    .status_lo, .status_hi, .rd_addr, .rd_byte, .cmd_valid, .cmd_op, .cmd_arg, .cmd_drop,
    .write_latch_bit, .vol_enable, .power_down, .cont_mode, .wrap_length_bits, .prog_overrun,
    .prog_data, .prog_valid, .prog_ready);
  sfd_host host (.ref_clk, .cs_n, .sclk, .h, .io({line3, line2, line1, line0}));
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    if (cmd_valid === 1'b1) n_val++;
    if (cmd_drop === 1'b1) n_drop++;
  end
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic op1(input logic [7:0] op);
    host.start();
    host.xfer(op, 1, 1, rx);
    host.stop();
  endtask
  task automatic addr(input logic [23:0] a);
    for (int k = 2; k >= 0; k--) host.xfer(a[8*k+:8], 1, 1, rx);
  endtask
  task automatic t_status();
    busy = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      host.start();
      host.xfer(k ? 8'h35 : 8'h05, 1, 1, rx);
      repeat (2)
      begin
        host.xfer(8'h00, 1, 0, rx);
        chk("status", k ? status_hi : status_lo, rx);
      end
      host.stop();
    end
    op1(8'h06);
    chk("latch busy", 0, write_latch_bit);
    busy = 1'b0;
  endtask
  task automatic t_cmds();
    logic [7:0] ops [6] = '{8'h06, 8'h50, 8'h04, 8'hb9, 8'h75, 8'h7a};
    logic [2:0] lv [6] = '{3'h1, 3'h3, 3'h0, 3'h4, 3'h4, 3'h4};
    int v;
    foreach (ops[k])
    begin
      v = n_val;
      op1(ops[k]);
      chk("op", ops[k], cmd_op);
      chk("taken", v + 1, n_val);
      chk("levels", lv[k], {power_down, vol_enable, write_latch_bit});
    end
    host.start();
    host.xfer(8'h12, 1, 1, rx);
    host.xfer(8'h00, 1, 0, rx);
    chk("unknown en", 0, {line3_en, line2_en, line1_en, line0_en});
    host.stop();
  endtask
  task automatic t_prog();
    logic [7:0] er [5] = '{8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60};
    int v;
    prog_ready = 1'b0;
    op1(8'h06);
    host.start();
    host.xfer(8'h32, 1, 1, rx);
    addr(24'h012345);
    for (int i = 0; i < 17; i++) host.xfer(8'(8'h10 + i), 4, 1, rx);
    host.stop();
    chk("prog op", 8'h32, cmd_op);
    chk("prog addr", 24'h012345, cmd_arg);
    chk("latch used", 0, write_latch_bit);
    chk("overrun", 1, prog_overrun);
    for (int i = 0; i < 16; i++)
    begin
      chk("prog data", {1'b1, 8'(8'h10 + i)}, {prog_valid, prog_data});
      prog_ready = 1'b1;
      @(negedge ref_clk);
      prog_ready = 1'b0;
      @(negedge ref_clk);
    end
    chk("drained", 0, prog_valid);
    v = n_drop;
    host.start();
    host.xfer(8'h02, 1, 1, rx);
    addr(24'h000000);
    host.xfer(8'h55, 1, 1, rx);
    host.stop();
    chk("drop latch", v + 1, n_drop);
    op1(8'h06);
    host.start();
    host.xfer(8'h20, 1, 1, rx);
    addr(24'h000000);
    host.xfer(8'h00, 4, 1, rx);
    host.stop();
    chk("drop partial", v + 2, n_drop);
    foreach (er[k])
    begin
      op1(8'h06);
      host.start();
      host.xfer(er[k], 1, 1, rx);
      if (k < 3) addr(24'h0a0000 + 24'(k));
      host.stop();
      chk("erase op", er[k], cmd_op);
      if (k < 3) chk("erase addr", 24'h0a0000 + 24'(k), cmd_arg);
    end
    op1(8'h06);
    host.start();
    host.xfer(8'h01, 1, 1, rx);
    host.xfer(8'h3c, 1, 1, rx);
    host.xfer(8'h02, 1, 1, rx);
    host.stop();
    chk("status write", 24'h01023c, cmd_arg);
  endtask
  task automatic t_read();
    logic [7:0] ops [4] = '{8'h03, 8'h0b, 8'h3b, 8'h6b};
    int w [4] = '{1, 1, 2, 4};
    logic [23:0] a;
    foreach (ops[k])
    begin
      a = 24'h0001fe + 24'(k);
      host.start();
      host.xfer(ops[k], 1, 1, rx);
      addr(a);
      if (k > 0) host.xfer(8'h00, 1, 1, rx);
      for (int j = 0; j < 2; j++)
      begin
        host.xfer(8'h00, w[k], 0, rx);
        chk("read", 8'(a + 24'(j)) ^ 8'h5a, rx);
      end
      // two more clocks, then select rises mid-byte, or after a whole byte for 6bh
      host.xfer(8'h00, 4, 0, rx);
      host.stop();
      chk("read en", 0, {line3_en, line2_en, line1_en});
    end
  endtask
  // quad address and mode; op 00 gives a frame without opcode in continuous mode
  task automatic t_qio(input logic [7:0] op, input logic [7:0] m, input logic c);
    logic [7:0] b [4];
    b = '{8'h00, 8'h12, 8'h34, m};
    host.start();
    if (op != 8'h00) host.xfer(op, 1, 1, rx);
    foreach (b[k]) host.xfer(b[k], 4, 1, rx);
    repeat (2) host.xfer(8'h00, 4, 0, rx);
    chk("quad read", 8'h34 ^ 8'h5a, rx);
    host.stop();
    chk("cont mode", c, cont_mode);
  endtask
  task automatic t_quad();
    host.start();
    host.xfer(8'h77, 1, 1, rx);
    for (int i = 0; i < 4; i++) host.xfer(i == 3 ? 8'h5f : 8'hff, 4, 1, rx);
    host.stop();
    chk("wrap", 3'h5, wrap_length_bits);
    t_qio(8'he7, 8'h20, 1);
    t_qio(8'h00, 8'h00, 0);
    t_qio(8'he7, 8'h20, 1);
    host.start();
    repeat (2) host.xfer(8'hff, 1, 1, rx);
    host.stop();
    chk("mode reset", 0, cont_mode);
    host.start();
    host.xfer(8'h9f, 1, 1, rx);
    host.xfer(8'h00, 1, 0, rx);
    chk("maker id", dut.MAKER_CODE, rx);
    host.stop();
  endtask
  initial
  begin
    reset_n = 1'b0;
    busy = 1'b0;
    prog_ready = 1'b0;
    status_lo = 8'hc4;
    status_hi = 8'h81;
    repeat (8) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    t_status();
    t_cmds();
    t_prog();
    t_read();
    t_quad();
    report_and_stop();
  end
  initial
  begin
    // traffic needs about 7k cycles
    repeat (60000) @(posedge ref_clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule
